// [core/bcu_consts.vh]
// opcode, flag position and timing constants for the branch condition unit
`ifndef BCU_CONSTS_VH
`define BCU_CONSTS_VH
// relative branch opcodes, 8 bits
`define BCU_OP_ALWAYS 8'h20
`define BCU_OP_NEVER 8'h21
`define BCU_OP_UNS_HIGHER 8'h22
`define BCU_OP_UNS_LOWER_SAME 8'h23
`define BCU_OP_CARRY_CLEAR 8'h24
`define BCU_OP_CARRY_SET 8'h25
`define BCU_OP_NOT_EQUAL 8'h26
`define BCU_OP_EQUAL 8'h27
`define BCU_OP_NO_OVERFLOW 8'h28
`define BCU_OP_OVERFLOW 8'h29
`define BCU_OP_PLUS 8'h2a
`define BCU_OP_MINUS 8'h2b
`define BCU_OP_SIGNED_GE 8'h2c
`define BCU_OP_SIGNED_LT 8'h2d
`define BCU_OP_SIGNED_GT 8'h2e
`define BCU_OP_SIGNED_LE 8'h2f
// condition code bit positions: s x h i n z v c
`define BCU_CCR_C 0
`define BCU_CCR_V 1
`define BCU_CCR_Z 2
`define BCU_CCR_N 3
// pc step past the two-byte branch
`define BCU_PC_STEP 16'h0002
// program fetch cycles, taken and untaken
`define BCU_FETCH_TAKEN 2'h3
`define BCU_FETCH_UNTAKEN 2'h1
// reset values
`define BCU_PC_RESET 16'h0000
`define BCU_CCR_RESET 8'h00
`endif

// [core/bcu_branch_condition_unit.v]
// branch condition unit: evaluates relative branches and sequences queue refill
`timescale 1ns/100ps
`default_nettype none
`include "bcu_consts.vh"

module bcu_branch_condition_unit #(
  parameter PC_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire br_valid,
  input wire [7:0] br_opcode,
  input wire [7:0] br_offset,
  input wire [PC_W-1:0] br_pc,
  input wire [7:0] ccr_in,
  output wire br_ready,
  output reg [PC_W-1:0] pc_out,
  output reg pc_load,
  output reg [7:0] ccr_out,
  output reg taken,
  output reg fetch_req,
  output reg busy,
  output reg done
);

  // sequencer states
  localparam ST_IDLE = 1'b0;
  localparam ST_FETCH = 1'b1;

  // constants at their working widths, so no sum silently pads or cuts
  localparam [PC_W-1:0] PC_STEP = `BCU_PC_STEP;
  localparam [PC_W-1:0] PC_RESET = `BCU_PC_RESET;
  localparam [1:0] FETCH_TAKEN = `BCU_FETCH_TAKEN;
  localparam [1:0] FETCH_UNTAKEN = `BCU_FETCH_UNTAKEN;

  // sequencer and decode state
  reg state;
  reg [1:0] fetch_left;
  reg cond_true;
  reg is_branch;

  // next value of every flop
  reg next_state;
  reg [1:0] next_fetch_left;
  reg [PC_W-1:0] next_pc_out;
  reg next_pc_load;
  reg [7:0] next_ccr_out;
  reg next_taken;
  reg next_fetch_req;
  reg next_busy;
  reg next_done;

  // flag taps and branch arithmetic
  wire flag_c;
  wire flag_v;
  wire flag_z;
  wire flag_n;
  wire [PC_W-1:0] ofs_ext;
  wire [PC_W-1:0] pc_next_seq;
  wire [PC_W-1:0] pc_target;
  wire accept;
  genvar k;

  assign flag_c = ccr_in[`BCU_CCR_C];
  assign flag_v = ccr_in[`BCU_CCR_V];
  assign flag_z = ccr_in[`BCU_CCR_Z];
  assign flag_n = ccr_in[`BCU_CCR_N];

  // offset is a signed byte: every bit above it copies the sign bit
  assign ofs_ext[7:0] = br_offset;
  generate
    for (k = 8; k < PC_W; k = k + 1)
    begin : g_sext
      assign ofs_ext[k] = br_offset[7];
    end
  endgenerate

  // pc step past the two-byte branch, then the relative hop
  assign pc_next_seq = br_pc + PC_STEP;
  assign pc_target = pc_next_seq + ofs_ext;

  // new branch accepted only when the previous refill is over, which
  // keeps a taken branch from being cut short by the next request
  assign br_ready = (state == ST_IDLE);
  assign accept = br_valid & br_ready & is_branch;

  // condition decode over the relative branch table
  always @*
  begin
    cond_true = 1'b0;
    is_branch = 1'b1;
    case (br_opcode)
      `BCU_OP_ALWAYS: cond_true = 1'b1;
      `BCU_OP_NEVER: cond_true = 1'b0;
      `BCU_OP_UNS_HIGHER: cond_true = ~(flag_c | flag_z);
      `BCU_OP_UNS_LOWER_SAME: cond_true = flag_c | flag_z;
      `BCU_OP_CARRY_CLEAR: cond_true = ~flag_c;
      `BCU_OP_CARRY_SET: cond_true = flag_c;
      `BCU_OP_NOT_EQUAL: cond_true = ~flag_z;
      `BCU_OP_EQUAL: cond_true = flag_z;
      `BCU_OP_NO_OVERFLOW: cond_true = ~flag_v;
      `BCU_OP_OVERFLOW: cond_true = flag_v;
      `BCU_OP_PLUS: cond_true = ~flag_n;
      `BCU_OP_MINUS: cond_true = flag_n;
      `BCU_OP_SIGNED_GE: cond_true = ~(flag_n ^ flag_v);
      `BCU_OP_SIGNED_LT: cond_true = flag_n ^ flag_v;
      `BCU_OP_SIGNED_GT: cond_true = ~(flag_z | (flag_n ^ flag_v));
      `BCU_OP_SIGNED_LE: cond_true = flag_z | (flag_n ^ flag_v);
      default: is_branch = 1'b0;
    endcase
  end

  // next values: every output except br_ready (a decode of state) is a flop, so the queue sees clean levels
  // one cycle after the accept edge
  always @*
  begin
    next_state = state;
    next_fetch_left = fetch_left;
    next_pc_out = pc_out;
    next_pc_load = 1'b0;
    next_ccr_out = ccr_out;
    next_taken = taken;
    next_fetch_req = fetch_req;
    next_busy = busy;
    next_done = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_fetch_req = 1'b0;
        next_busy = 1'b0;
        // non-branch opcodes are ignored, never half-executed
        if (accept)
        begin
          next_ccr_out = ccr_in;
          next_taken = cond_true;
          next_pc_load = 1'b1;
          next_fetch_req = 1'b1;
          next_busy = 1'b1;
          // the first fetch is issued now, so count only the rest
          if (cond_true)
          begin
            next_pc_out = pc_target;
            next_fetch_left = FETCH_TAKEN - 2'h1;
            next_state = ST_FETCH;
          end
          else
          begin
            next_pc_out = pc_next_seq;
            next_fetch_left = FETCH_UNTAKEN - 2'h1;
            next_done = 1'b1;
          end
        end
      end
      ST_FETCH:
      begin
        // queue refill: one program fetch per cycle, done on the last one
        next_fetch_req = 1'b1;
        next_fetch_left = fetch_left - 2'h1;
        if (fetch_left == 2'h1)
        begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // sequencer state; reset loads constants only
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      fetch_left <= 2'h0;
    end
    else
    begin
      state <= next_state;
      fetch_left <= next_fetch_left;
    end
  end

  // results stand until the next accept: pc, flags and the taken level
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc_out <= PC_RESET;
      ccr_out <= `BCU_CCR_RESET;
      taken <= 1'b0;
    end
    else
    begin
      pc_out <= next_pc_out;
      ccr_out <= next_ccr_out;
      taken <= next_taken;
    end
  end

  // pulses and fetch levels toward the queue and fetch logic
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc_load <= 1'b0;
      fetch_req <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      pc_load <= next_pc_load;
      fetch_req <= next_fetch_req;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule // bcu_branch_condition_unit
`default_nettype wire

// [tb/bcu_fetch_model.sv]
// far side: counts program fetches per branch
`timescale 1ns/100ps
`default_nettype none
module bcu_fetch_model (input wire clk, sys_rst, fetch_req, pc_load, done,
  output reg [1:0] n_fetch);
  reg [1:0] run;
  wire [1:0] next_run = pc_load ? 2'h1 : run + 2'h1; // a load opens a new branch
  // count latched at done, the last fetch of the refill
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) {run, n_fetch} <= 4'h0;
    else if (fetch_req) {run, n_fetch} <= {next_run, done ? next_run : n_fetch};
endmodule // bcu_fetch_model
`default_nettype wire

// [tb/bcu_chk.sv]
// port checks for the branch unit
`timescale 1ns/100ps
`default_nettype none
module bcu_chk (input wire clk, sys_rst, br_valid, br_ready, pc_load, taken, done, busy,
  fetch_req, input wire [7:0] br_offset, ccr_in, ccr_out, br_opcode,
  input wire [15:0] br_pc, pc_out);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire go = br_valid & br_ready & (br_opcode[7:4] == 4'h2);
  wire zv = ccr_in[2] | (ccr_in[3] ^ ccr_in[1]); // z or (n xor v)
  wire [15:0] rel = {{8{br_offset[7]}}, br_offset};
  property p_pc; go |=> pc_out == $past(br_pc) + 16'h2 + (taken ? $past(rel) : 16'h0);
  endproperty
  a_pc: assert property (p_pc) else $error("pc wrong");
  property p_bv; go && br_opcode == 8'h28 |=> taken != $past(ccr_in[1]); endproperty
  a_bv: assert property (p_bv) else $error("v test wrong");
  property p_gt; go && br_opcode == 8'h2e |=> taken != $past(zv); endproperty
  a_gt: assert property (p_gt) else $error("gt wrong");
  property p_le; go && br_opcode == 8'h2f |=> taken == $past(zv); endproperty
  a_le: assert property (p_le) else $error("le wrong");
  property p_cc; go |=> pc_load && ccr_out == $past(ccr_in); endproperty
  a_cc: assert property (p_cc) else $error("flags moved");
  property p_ft; pc_load |-> if (taken) !done [*2] ##1 done else done; endproperty
  a_ft: assert property (p_ft) else $error("fetch count");
  property p_rd; go |=> if (taken) !br_ready [*2] ##1 br_ready else br_ready; endproperty
  a_rd: assert property (p_rd) else $error("ready window");
  property p_fq; (pc_load |-> busy && fetch_req) and (done && !go |=> !busy && !fetch_req);
  endproperty
  a_fq: assert property (p_fq) else $error("fetch level");
  property p_ig; br_valid && br_opcode[7:4] != 4'h2 |=> !pc_load; endproperty
  a_ig: assert property (p_ig) else $error("stray opcode taken");
  c_tk: cover property (pc_load && taken);
  c_nt: cover property (pc_load && !taken);
  c_le: cover property (go && br_opcode == 8'h2f);
endmodule // bcu_chk
bind bcu_branch_condition_unit bcu_chk u_bcu_chk (.*);
`default_nettype wire

// [tb/bcu_branch_condition_unit_tb.sv]
// random branch sweep against a flag model
`timescale 1ns/100ps
`default_nettype none
module bcu_branch_condition_unit_tb;
  reg clk = 0, sys_rst = 1, br_valid = 0;
  reg [7:0] br_opcode = 8'h20, br_offset = 8'h0, ccr_in = 8'h0, c, f;
  reg [15:0] br_pc = 16'h0, ep;
  wire br_ready, pc_load, taken, fetch_req, busy, done;
  wire [15:0] pc_out;
  wire [7:0] ccr_out;
  wire [1:0] n_fetch;
  integer n_mismatch = 0, checked = 0, i, t, e;
  initial forever #2 clk = ~clk;
  bcu_branch_condition_unit u_bcu_branch_condition_unit (.*);
  bcu_fetch_model u_bcu_fetch_model (.*);
  task close_out;
    begin
      if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [15:0] s, x);
    begin
      checked = checked + 1;
      if (s !== x) $display("[ERR] %0t %h %h", $time, s, x);
      n_mismatch = n_mismatch + (s !== x);
    end
  endtask
  initial
  begin
    i = $urandom(32'hcffd);
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    // four sweeps over all sixteen opcodes
    for (i = 0; i < 64; i = i + 1)
    begin
      // a stray opcode outside the branch table first; it must be ignored
      @(posedge clk);
      br_valid <= 1;
      br_opcode <= 8'h30 + 8'($urandom % 32'hf0);
      @(posedge clk);
      {c, f, ep} = $urandom;
      br_opcode <= {4'h2, i[3:0]};
      {ccr_in, br_offset, br_pc} <= {c, f, ep};
      e = {!(c[2] | (c[3] ^ c[1])), !(c[3] ^ c[1]), !c[3], !c[1], !c[2], !c[0],
        !(c[0] | c[2]), 1'b1} >> i[3:1];
      e = (e ^ i) & 1; // odd opcodes test the complement
      ep = ep + 16'h2 + (e ? {{8{f[7]}}, f} : 16'h0);
      @(posedge clk);
      br_valid <= 0;
      #1;
      for (t = 0; done !== 1'b1; t = t + 1)
      begin
        if (t > 9)
        begin
          n_mismatch = n_mismatch + 1;
          close_out;
        end
        @(posedge clk);
        #1;
      end
      chk(pc_out, ep);
      chk(taken, e);
      @(posedge clk);
      #1;
      chk(n_fetch, e ? 3 : 1);
    end
    close_out;
  end
endmodule // bcu_branch_condition_unit_tb
`default_nettype wire
